// ### core/rct_pkg.sv
// Purpose: Shared constants for the countdown timer block
// Assumes: 100 MHz system clock, one synchronous reset
// Notes: Register offsets are byte addresses on the register port
package rct_pkg;
  // ----------------------------------------------------------------
  // Clock and source rates
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SRC_FAST_HZ = 4096;
  // Fast tick period, the shortest source period, rounded down to whole cycles
  localparam int unsigned CYC_PER_FAST = CLK_HZ / SRC_FAST_HZ;
  localparam int unsigned FAST_PER_64HZ = 64;
  localparam int unsigned FAST_PER_1HZ = 4096;
  localparam int unsigned SEC_PER_MIN = 60;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_CONTROL = 8'h11;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam int unsigned SEL_LSB = 3;
  localparam int unsigned RUN_BIT = 2;
  localparam int unsigned IRQ_EN_BIT = 1;
  localparam int unsigned PULSE_BIT = 0;
  localparam logic [1:0] SEL_RST = 2'h3;
  localparam logic RUN_RST = 1'b0;
  localparam logic IRQ_EN_RST = 1'b0;
  localparam logic PULSE_RST = 1'b0;
  // ----------------------------------------------------------------
  // Source clock select codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_4096HZ = 2'h0,
    SRC_64HZ = 2'h1,
    SRC_1HZ = 2'h2,
    SRC_1_60HZ = 2'h3
  } rct_src_t;
endpackage

// ### core/rct_prescaler.sv
// Purpose: Divides the system clock into the four timer source ticks
// Assumes: Synchronous active high reset
// Notes: The fast tick rate is truncated, so it runs a touch fast
`timescale 1ns/1ps
module rct_prescaler #(
  parameter int unsigned CYC_PER_FAST = rct_pkg::CYC_PER_FAST
) (
  input wire logic clk_i,
  input wire logic rst_i,
  rct_tick_if.src ticks
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  generate
    if (CYC_PER_FAST < 2 || CYC_PER_FAST > 65536) begin : g_bad_div
      $error("rct_prescaler: CYC_PER_FAST out of range");
    end
  endgenerate

  logic [15:0] div_reg;
  logic [11:0] fast_reg;
  logic [5:0] sec_reg;
  logic fast_tick;

  assign fast_tick = (div_reg == 16'(CYC_PER_FAST - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || fast_tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // Fast ticks counted modulo 4096 give both the 64 Hz and 1 Hz rates
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_reg <= 12'h000;
    end else if (fast_tick) begin
      fast_reg <= fast_reg + 12'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_reg <= 6'h00;
    end else if (ticks.tick_1) begin
      if (sec_reg == 6'(rct_pkg::SEC_PER_MIN - 1)) begin
        sec_reg <= 6'h00;
      end else begin
        sec_reg <= sec_reg + 6'h01;
      end
    end
  end

  assign ticks.tick_4096 = fast_tick;
  assign ticks.tick_64 = fast_tick && (fast_reg[5:0] == 6'(rct_pkg::FAST_PER_64HZ - 1));
  assign ticks.tick_1 = fast_tick && (fast_reg == 12'(rct_pkg::FAST_PER_1HZ - 1));
  assign ticks.tick_1_60 = ticks.tick_1 && (sec_reg == 6'(rct_pkg::SEC_PER_MIN - 1));
endmodule

// ### core/rct_tick_if.sv
// Purpose: Carries the prescaled tick enables to the counter
// Assumes: All ticks are one-cycle pulses on the system clock
// Notes: Slower ticks coincide with a fast tick
`timescale 1ns/1ps
interface rct_tick_if;
  logic tick_4096;
  logic tick_64;
  logic tick_1;
  logic tick_1_60;
  modport src (output tick_4096, output tick_64, output tick_1, output tick_1_60);
  modport snk (input tick_4096, input tick_64, input tick_1, input tick_1_60);
endinterface

// ### core/rct_timer.sv
// Purpose: 8-bit countdown timer with count and control registers
// Assumes: Register port already decoded from the serial interface
// Notes: Flag storage is local; its clear arrives on FLAG_CLR_I
`timescale 1ns/1ps
module rct_timer #(
  parameter int unsigned CYC_PER_FAST = rct_pkg::CYC_PER_FAST
) (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic FLAG_CLR_I,
  output logic COUNTDOWN_FLAG_O,
  output logic TIMER_IRQ_O
);
  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  rct_tick_if ticks ();

  rct_prescaler #(
    .CYC_PER_FAST(CYC_PER_FAST)
  ) u_prescaler (
    .clk_i(MCLK_I),
    .rst_i(SRST_I),
    .ticks(ticks)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] reload_reg;
  logic [7:0] count_reg;
  rct_pkg::rct_src_t sel_reg;
  logic run_reg;
  logic irq_en_reg;
  logic pulse_sel_reg;
  logic flag_reg;
  logic [15:0] pulse_cnt_reg;
  logic [7:0] rdata_reg;

  // ----------------------------------------------------------------
  // Decode and sequencing nets
  // ----------------------------------------------------------------
  logic wr_count;
  logic wr_control;
  logic rd_count;
  logic rd_control;
  logic src_tick;
  logic count_live;
  logic count_step;
  logic count_end;
  logic pulse_live;
  logic irq_source;
  logic [7:0] control_word;

  // ----------------------------------------------------------------
  // Derived constants
  // ----------------------------------------------------------------
  // Half a fast period keeps every pulse shorter than the shortest countdown
  localparam int unsigned PULSE_CYC = CYC_PER_FAST / 2;
  localparam logic [15:0] PULSE_LOAD = 16'(PULSE_CYC);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  generate
    if (CYC_PER_FAST < 2 || CYC_PER_FAST > 65536) begin : g_bad_div
      $error("rct_timer: CYC_PER_FAST out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Shared by the write and read decoders
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
    addr_hit = (addr == offset);
  endfunction

  // Host view of control; unused upper bits read as zero
  function automatic logic [7:0] pack_control(
    input rct_pkg::rct_src_t sel,
    input logic run,
    input logic irq_en,
    input logic pulse_sel
  );
    logic [7:0] word;
    word = 8'h00;
    word[rct_pkg::SEL_LSB +: 2] = sel;
    word[rct_pkg::RUN_BIT] = run;
    word[rct_pkg::IRQ_EN_BIT] = irq_en;
    word[rct_pkg::PULSE_BIT] = pulse_sel;
    pack_control = word;
  endfunction

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign wr_count = REG_WR_I && addr_hit(REG_ADDR_I, rct_pkg::ADDR_COUNT);
  assign wr_control = REG_WR_I && addr_hit(REG_ADDR_I, rct_pkg::ADDR_CONTROL);
  assign rd_count = REG_RD_I && addr_hit(REG_ADDR_I, rct_pkg::ADDR_COUNT);
  assign rd_control = REG_RD_I && addr_hit(REG_ADDR_I, rct_pkg::ADDR_CONTROL);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Bits 7:5 are dropped on write, so they cannot disturb the timer
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      sel_reg <= rct_pkg::rct_src_t'(rct_pkg::SEL_RST);
      run_reg <= rct_pkg::RUN_RST;
      irq_en_reg <= rct_pkg::IRQ_EN_RST;
      pulse_sel_reg <= rct_pkg::PULSE_RST;
    end else if (wr_control) begin
      sel_reg <= rct_pkg::rct_src_t'(REG_WDATA_I[rct_pkg::SEL_LSB +: 2]);
      run_reg <= REG_WDATA_I[rct_pkg::RUN_BIT];
      irq_en_reg <= REG_WDATA_I[rct_pkg::IRQ_EN_BIT];
      pulse_sel_reg <= REG_WDATA_I[rct_pkg::PULSE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Source clock select
  // ----------------------------------------------------------------
  always_comb begin
    case (sel_reg)
      rct_pkg::SRC_4096HZ: begin
        src_tick = ticks.tick_4096;
      end
      rct_pkg::SRC_64HZ: begin
        src_tick = ticks.tick_64;
      end
      rct_pkg::SRC_1HZ: begin
        src_tick = ticks.tick_1;
      end
      rct_pkg::SRC_1_60HZ: begin
        src_tick = ticks.tick_1_60;
      end
      default: begin
        src_tick = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Countdown sequencing
  // ----------------------------------------------------------------
  assign count_live = (count_reg != 8'h00);
  assign count_step = run_reg && src_tick && count_live;
  assign count_end = count_step && (count_reg == 8'h01);

  // Reload value, kept apart from the live count
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      reload_reg <= rct_pkg::COUNT_RST;
    end else if (wr_count) begin
      reload_reg <= REG_WDATA_I;
    end
  end

  // A write lands at once, even mid-period; the prescaler runs free, so the first period can be short even if stopped
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      count_reg <= rct_pkg::COUNT_RST;
    end else if (wr_count) begin
      count_reg <= REG_WDATA_I;
    end else if (count_end) begin
      count_reg <= reload_reg;
    end else if (count_step) begin
      count_reg <= count_reg - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Timer flag
  // ----------------------------------------------------------------
  // A terminal count in the clear cycle wins, so no event is lost
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      flag_reg <= 1'b0;
    end else if (count_end) begin
      flag_reg <= 1'b1;
    end else if (FLAG_CLR_I) begin
      flag_reg <= 1'b0;
    end
  end

  assign COUNTDOWN_FLAG_O = flag_reg;

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      pulse_cnt_reg <= 16'h0000;
    end else if (count_end) begin
      pulse_cnt_reg <= PULSE_LOAD;
    end else if (pulse_live) begin
      pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
    end
  end

  assign pulse_live = (pulse_cnt_reg != 16'h0000);

  // Level style follows the flag; pulse style starts with it
  always_comb begin
    if (pulse_sel_reg) begin
      irq_source = pulse_live;
    end else begin
      irq_source = flag_reg;
    end
  end

  assign TIMER_IRQ_O = irq_en_reg && irq_source;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  assign control_word = pack_control(sel_reg, run_reg, irq_en_reg, pulse_sel_reg);

  // Read data is held between reads, so the host may sample it late
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      rdata_reg <= 8'h00;
    end else if (rd_count) begin
      rdata_reg <= count_reg;
    end else if (rd_control) begin
      rdata_reg <= control_word;
    end else if (REG_RD_I) begin
      rdata_reg <= 8'h00;
    end
  end

  assign REG_RDATA_O = rdata_reg;
endmodule

// ### testbench/rct_host.sv
// Purpose: Host model driving the timer register port
// Assumes: Port inputs change on the falling edge
// Notes: Read data taken one rising edge after the strobe
`timescale 1ns/1ps
module rct_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o
);
  initial {addr_o, wr_o, wdata_o, rd_o} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i) {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
    @(negedge clk_i) wr_o = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i) {addr_o, rd_o} = {a, 1'b1};
    @(negedge clk_i) d = rdata_i;
    rd_o = 1'b0;
  endtask
endmodule

// ### testbench/rct_timer_chk.sv
// Purpose: Port checks of the countdown timer
// Assumes: Control shadow follows port writes
// Notes: Pulse bound suits a shortened fast tick
`timescale 1ns/1ps
module rct_timer_chk (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic FLAG_CLR_I,
  input wire logic COUNTDOWN_FLAG_O,
  input wire logic TIMER_IRQ_O
);
  logic [7:0] ctl_reg;
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) ctl_reg <= 8'h18;
    else if (REG_WR_I && REG_ADDR_I == rct_pkg::ADDR_CONTROL) ctl_reg <= REG_WDATA_I;
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  property p_hold; $fell(COUNTDOWN_FLAG_O) |-> $past(FLAG_CLR_I); endproperty
  a_hold: assert property (p_hold) else $error("flag fell alone");
  property p_run; $rose(COUNTDOWN_FLAG_O) |-> $past(ctl_reg[2]); endproperty
  a_run: assert property (p_run) else $error("flag while stopped");
  property p_gate; !ctl_reg[1] [*2] |-> !TIMER_IRQ_O; endproperty
  a_gate: assert property (p_gate) else $error("irq not gated");
  property p_lvl; (ctl_reg[1:0] == 2'h2) [*2] |-> TIMER_IRQ_O == COUNTDOWN_FLAG_O; endproperty
  a_lvl: assert property (p_lvl) else $error("irq not level");
  property p_pls; ctl_reg[1:0] == 2'h3 && $rose(TIMER_IRQ_O) |-> ##[1:300] !TIMER_IRQ_O; endproperty
  a_pls: assert property (p_pls) else $error("irq pulse stuck");
  property p_sync; $rose(TIMER_IRQ_O) |-> COUNTDOWN_FLAG_O; endproperty
  a_sync: assert property (p_sync) else $error("irq without flag");
  property p_clr; FLAG_CLR_I && !ctl_reg[2] |=> !COUNTDOWN_FLAG_O; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_rdc; REG_RD_I && REG_ADDR_I == 8'h11 |=> REG_RDATA_O[4:0] == ctl_reg[4:0]; endproperty
  a_rdc: assert property (p_rdc) else $error("control readback");
  cover property ($rose(COUNTDOWN_FLAG_O));
  cover property ($rose(TIMER_IRQ_O) && ctl_reg[0]);
  cover property (FLAG_CLR_I && COUNTDOWN_FLAG_O);
endmodule

// ### testbench/rct_timer_tb.sv
// Purpose: Register-level test of the countdown timer
// Assumes: Fast tick shortened to 16 cycles
// Notes: 1 Hz and slower sources are only read back, too long to run
`timescale 1ns/1ps
module rct_timer_tb;
  logic clk = 0, rst = 1, clr = 0, wr, rd, flag, irq;
  logic [7:0] addr, wd, rdat, v;
  int fail_count = 0, compares = 0;
  int cyc;
  localparam int unsigned CYC = 16;
  always #5 clk = ~clk;
  rct_host i_host (.clk_i(clk), .rdata_i(rdat), .addr_o(addr), .wr_o(wr), .wdata_o(wd), .rd_o(rd));
  rct_timer #(.CYC_PER_FAST(CYC)) i_dut (.MCLK_I(clk), .SRST_I(rst), .REG_ADDR_I(addr),
    .REG_WR_I(wr), .REG_WDATA_I(wd), .REG_RD_I(rd), .REG_RDATA_O(rdat), .FLAG_CLR_I(clr),
    .COUNTDOWN_FLAG_O(flag), .TIMER_IRQ_O(irq));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    i_host.rd(a, v);
    chk(n, e, v & m);
  endtask
  task automatic final_report();
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic clear();
    @(negedge clk) clr = 1'b1;
    @(negedge clk) clr = 1'b0;
  endtask
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rc("count rst", 8'h10, 8'h00, 8'hFF);
    rc("ctl rst", 8'h11, 8'h18, 8'h1F);
    for (int s = 0; s < 4; s++) begin
      i_host.wr(8'h11, 8'(s << 3));
      rc("sel", 8'h11, 8'(s << 3), 8'h1F);
    end
    i_host.wr(8'h10, 8'hFF);
    i_host.wr(8'h11, 8'h04);
    repeat (100) @(negedge clk);
    i_host.rd(8'h10, v);
    chk("live", 8'h01, {7'h0, v < 8'hFF && v > 8'hF0});
    i_host.wr(8'h11, 8'h00);
    i_host.wr(8'h10, 8'h03);
    i_host.wr(8'h11, 8'hE6);
    for (int i = 0; i < 400 && flag !== 1'b1; i++) @(negedge clk);
    chk("flag set", 8'h01, {7'h0, flag});
    chk("irq lvl", 8'h01, {7'h0, irq});
    i_host.wr(8'h10, 8'h00);
    clear();
    chk("flag clr", 8'h00, {7'h0, flag});
    chk("irq follow", 8'h00, {7'h0, irq});
    repeat (200) @(negedge clk);
    chk("zero halt", 8'h00, {7'h0, flag});
    rc("zero cnt", 8'h10, 8'h00, 8'hFF);
    i_host.wr(8'h10, 8'h02);
    i_host.wr(8'h11, 8'h07);
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(negedge clk);
    chk("irq pls", 8'h01, {7'h0, irq & flag});
    repeat (10) @(negedge clk);
    chk("pls end", 8'h00, {7'h0, irq});
    chk("flag kept", 8'h01, {7'h0, flag});
    i_host.wr(8'h11, 8'h00);
    clear();
    i_host.wr(8'h10, 8'h02);
    i_host.wr(8'h11, 8'h0C);
    for (int i = 0; i < 3000 && flag !== 1'b1; i++) @(negedge clk);
    chk("flag 64", 8'h01, {7'h0, flag});
    chk("irq gated", 8'h00, {7'h0, irq});
    clear();
    for (cyc = 0; cyc < 3000 && flag !== 1'b1; cyc++) @(negedge clk);
    // Two cycles of the period go to the clear
    chk("period 64", 16'(2 * rct_pkg::FAST_PER_64HZ * CYC - 2), 16'(cyc));
    final_report();
  end
endmodule
bind rct_timer rct_timer_chk i_chk (
  .MCLK_I(MCLK_I),
  .SRST_I(SRST_I),
  .REG_ADDR_I(REG_ADDR_I),
  .REG_WR_I(REG_WR_I),
  .REG_WDATA_I(REG_WDATA_I),
  .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O),
  .FLAG_CLR_I(FLAG_CLR_I),
  .COUNTDOWN_FLAG_O(COUNTDOWN_FLAG_O),
  .TIMER_IRQ_O(TIMER_IRQ_O)
);
